// File: shared/jbt_pkg.sv
// Constants, types and helpers for the boundary scan test port.
// Assumes one test clock domain at the pins and one core clock domain.
//
// Notes on behaviour
// - Serial inputs sampled on test clock rise; serial output changes on its fall.
// - Mode select sampled each test clock rise; undriven pin reads high via pull-up.
// - Scan registers shift toward LSB; input enters MSB, output leaves LSB.
// - Five mode-select-high rises reset the test logic without disturbing memory.
// - Power-up reset leaves the serial output floating.
// - Three-bit instruction; the instruction picks exactly one data register.
// - Power-up and Test-Logic-Reset make IDCODE the current instruction.
// - Capture-IR loads 01 into the two low instruction bits.
// - One-bit bypass captures low and sits in the path under BYPASS.
// - Boundary register captures pin states in Capture-DR, shifts in Shift-DR.
// - IDCODE captures a fixed 32-bit identification word and shifts it out.
// - Instructions shift in Shift-IR and take effect only at Update-IR.
// - SAMPLE Z selects the boundary register and floats read data until the next Update-IR or Test-Logic-Reset.
// - SAMPLE/PRELOAD snapshots all pins in Capture-DR; shifting out and in overlap.
// - Update-DR copies shifted boundary contents into the latched parallel stage.
// - EXTEST drives output pins from latched values and selects the boundary register.
// - Cell 108 under EXTEST: latched high drives read data, low floats it.
// - Output-enable cell is preset low at power-up and Test-Logic-Reset.
package jbt_pkg;

    // ==========================================================
    // Widths and defaults
    localparam int IR_W = 3;
    localparam int ID_W = 32;
    localparam int BSR_LEN_DEFAULT = 109;
    localparam int OE_CELL_DEFAULT = 108;
    localparam int Q_W_DEFAULT = 36;
    localparam int Q_BASE_DEFAULT = 0;
    localparam int SYNC_W = 3;

    // ==========================================================
    // Instruction codes
    localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
    localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
    localparam logic [IR_W-1:0] INS_SAMPLEZ = 3'h2;
    localparam logic [IR_W-1:0] INS_SAMPLE = 3'h4;
    localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;

    // ==========================================================
    // Capture and reset values
    localparam logic [IR_W-1:0] IR_CAPTURE_VALUE = 3'h1;
    localparam logic [IR_W-1:0] IR_RESET_VALUE = INS_IDCODE;
    localparam logic BYPASS_CAPTURE_VALUE = 1'h0;
    localparam logic OE_CELL_RESET_VALUE = 1'h0;
    // Arbitrary identification word; bit 0 set as the serial format needs
    localparam logic [ID_W-1:0] ID_VALUE_DEFAULT = 32'h0a5c_3001;

    // ==========================================================
    // Controller states, Gray coded along the usual path
    typedef enum logic [3:0] {
        ST_RESET = 4'h0,
        ST_IDLE = 4'h1,
        ST_SEL_DR = 4'h3,
        ST_CAP_DR = 4'h2,
        ST_SHIFT_DR = 4'h6,
        ST_EXIT1_DR = 4'h7,
        ST_PAUSE_DR = 4'h5,
        ST_EXIT2_DR = 4'h4,
        ST_UPD_DR = 4'hc,
        ST_SEL_IR = 4'hd,
        ST_CAP_IR = 4'hf,
        ST_SHIFT_IR = 4'he,
        ST_EXIT1_IR = 4'ha,
        ST_PAUSE_IR = 4'hb,
        ST_EXIT2_IR = 4'h9,
        ST_UPD_IR = 4'h8
    } jbt_state_type;

    typedef enum logic [1:0] {
        SEL_BYPASS = 2'h0,
        SEL_ID = 2'h1,
        SEL_BSR = 2'h2
    } jbt_dr_sel_type;

    // Modes passed from the test clock domain to the core
    typedef struct packed {
        logic extest;
        logic float_q;
    } jbt_mode_type;

    // ==========================================================
    // Data register chosen by an instruction
    function automatic jbt_dr_sel_type dr_select(input logic [IR_W-1:0] ins);
        jbt_dr_sel_type sel;
        sel = SEL_BYPASS;
        if (ins == INS_IDCODE) begin
            sel = SEL_ID;
        end else if (ins == INS_EXTEST || ins == INS_SAMPLE || ins == INS_SAMPLEZ) begin
            sel = SEL_BSR;
        end
        return sel;
    endfunction : dr_select

endpackage : jbt_pkg

// File: test/jbt_jtag_ctl.sv
// Board test controller model driving the test clock, mode select and serial input.
// Assumes the bench calls its tasks; the test clock stands low between scans.
`timescale 1ns/100ps
module jbt_jtag_ctl (
    // Toward the device
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    // From the device
    input wire logic tdo_i,
    input wire logic tdo_oe_n_i
);
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
    end
    // ========
    // One 160 ns test clock period; levels change while the clock is low
    task automatic step(input logic m, input logic d, output logic o);
        tms_o = m;
        tdi_o = d;
        #40;
        // A floating serial output has no pull, so show the inverse of the held bit
        o = tdo_oe_n_i ? ~tdo_i : tdo_i;
        #40;
        tck_o = 1'b1;
        #80;
        tck_o = 1'b0;
    endtask : step
    task automatic tap_reset();
        logic o;
        #3;
        repeat (5) step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
    endtask : tap_reset
    // Whole scan from idle back to idle, first bit out in dout[0]
    task automatic scan(input logic ir, input int n, input logic [127:0] din,
                        output logic [127:0] dout);
        logic o;
        dout = '0;
        #3;
        step(1'b1, 1'b1, o);
        if (ir) step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
        step(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
    endtask : scan
endmodule : jbt_jtag_ctl

// File: test/jbt_tap_chk.sv
// Assertions on the test port and read-data pins of jbt_tap.
// Assumes it is bound onto jbt_tap and sees only its ports.
`timescale 1ns/100ps
module jbt_tap_chk
    import jbt_pkg::*;
#(
    parameter int BSR_LEN = BSR_LEN_DEFAULT,
    parameter int Q_W = Q_W_DEFAULT,
    parameter logic [ID_W-1:0] ID_VALUE = ID_VALUE_DEFAULT
) (
    // Clocks and reset
    input wire logic CLOCK_I,
    input wire logic RST_I,
    input wire logic TCK_I,
    // Test port
    input wire logic TMS_I,
    input wire logic TDI_I,
    input wire logic TDO_O,
    input wire logic TDO_OE_N_O,
    // Pins and read data
    input wire logic [BSR_LEN-1:0] PIN_STATE_I,
    input wire logic [Q_W-1:0] Q_FUNC_I,
    input wire logic Q_FUNC_OE_I,
    input wire logic [Q_W-1:0] Q_O,
    input wire logic Q_OE_N_O
);
    // ========
    // Shadow controller: next state per state code, one nibble each
    localparam logic [63:0] NEXT_LOW = 64'heef1_bbe1_5656_2611;
    localparam logic [63:0] NEXT_HIGH = 64'haa03_9883_c74c_d730;
    logic [3:0] st_reg;
    logic [IR_W-1:0] sh_reg, ir_reg;
    logic [1:0] mode, mode_reg;
    logic [2:0] calm_reg;
    logic in_shift, by_sel;
    assign in_shift = st_reg == ST_SHIFT_IR || st_reg == ST_SHIFT_DR;
    assign by_sel = !(ir_reg inside {INS_EXTEST, INS_IDCODE, INS_SAMPLEZ, INS_SAMPLE});
    assign mode = {ir_reg == INS_EXTEST, ir_reg == INS_SAMPLEZ};
    always_ff @(posedge TCK_I or posedge RST_I) begin
        if (RST_I) begin
            st_reg <= ST_RESET;
            sh_reg <= '0;
            ir_reg <= INS_IDCODE;
        end else begin
            st_reg <= TMS_I ? NEXT_HIGH[{st_reg, 2'h0} +: 4] : NEXT_LOW[{st_reg, 2'h0} +: 4];
            if (st_reg == ST_CAP_IR) sh_reg <= 3'h1;
            if (st_reg == ST_SHIFT_IR) sh_reg <= {TDI_I, sh_reg[2:1]};
            if (st_reg == ST_UPD_IR) ir_reg <= sh_reg;
            if (st_reg == ST_RESET) ir_reg <= INS_IDCODE;
        end
    end
    // Mode must settle across the crossing before read data is judged
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            mode_reg <= 2'h0;
            calm_reg <= 3'h0;
        end else begin
            mode_reg <= mode;
            if (mode != mode_reg) calm_reg <= 3'h0;
            else if (calm_reg != 3'h7) calm_reg <= calm_reg + 3'h1;
        end
    end
    // ========
    // Properties
    sequence s_dr_enter;
        st_reg == ST_SHIFT_DR && $past(st_reg) == ST_CAP_DR;
    endsequence
    sequence s_ir_enter;
        st_reg == ST_SHIFT_IR && $past(st_reg) == ST_CAP_IR && !TMS_I;
    endsequence
    property p_tdo_edge;
        @(posedge CLOCK_I) disable iff (RST_I)
            $changed(TDO_O) || $changed(TDO_OE_N_O) |-> !TCK_I;
    endproperty
    property p_oe_shift;
        @(posedge TCK_I) disable iff (RST_I) TDO_OE_N_O == !in_shift;
    endproperty
    property p_five_high;
        @(posedge TCK_I) disable iff (RST_I) TMS_I [*5] |=> TDO_OE_N_O;
    endproperty
    property p_ir_cap;
        @(posedge TCK_I) disable iff (RST_I) s_ir_enter |-> TDO_O ##1 !TDO_O;
    endproperty
    property p_byp_first;
        @(posedge TCK_I) disable iff (RST_I)
            s_dr_enter ##0 by_sel |-> TDO_O == BYPASS_CAPTURE_VALUE;
    endproperty
    property p_byp_path;
        @(posedge TCK_I) disable iff (RST_I)
            st_reg == ST_SHIFT_DR && $past(st_reg) == ST_SHIFT_DR && by_sel
            |-> TDO_O == $past(TDI_I);
    endproperty
    property p_id_first;
        @(posedge TCK_I) disable iff (RST_I)
            s_dr_enter ##0 ir_reg == INS_IDCODE |-> TDO_O == ID_VALUE[0];
    endproperty
    property p_rst_float;
        @(posedge CLOCK_I) RST_I |-> TDO_OE_N_O && Q_OE_N_O;
    endproperty
    property p_q_normal;
        @(posedge CLOCK_I) disable iff (RST_I) calm_reg == 3'h7 && mode_reg == 2'h0
            |-> Q_O == $past(Q_FUNC_I) && Q_OE_N_O == !$past(Q_FUNC_OE_I);
    endproperty
    property p_q_float;
        @(posedge CLOCK_I) disable iff (RST_I) calm_reg == 3'h7 && mode_reg == 2'h1
            |-> Q_OE_N_O && Q_O == $past(Q_FUNC_I);
    endproperty
    a_tdo_edge: assert property (p_tdo_edge)
        else $error("serial output moved while test clock high");
    a_oe_shift: assert property (p_oe_shift)
        else $error("serial output enable outside shift states");
    a_five_high: assert property (p_five_high)
        else $error("serial output enabled after five mode-select highs");
    a_ir_cap: assert property (p_ir_cap)
        else $error("instruction capture pattern wrong");
    a_byp_first: assert property (p_byp_first)
        else $error("bypass bit not captured low");
    a_byp_path: assert property (p_byp_path)
        else $error("bypass path delay wrong");
    a_id_first: assert property (p_id_first)
        else $error("identification word bit 0 wrong");
    a_rst_float: assert property (p_rst_float)
        else $error("outputs enabled during power-up reset");
    a_q_normal: assert property (p_q_normal)
        else $error("read data disturbed outside test modes");
    a_q_float: assert property (p_q_float)
        else $error("read data driven while floating");
endmodule : jbt_tap_chk

// File: test/tb.sv
// Self-checking bench for the boundary scan test port.
// Assumes the controller model jbt_jtag_ctl and the checker bound below.
`timescale 1ns/100ps
module tb;
    import jbt_pkg::*;
    logic clk, rst, tck, tms, tdi, tdo, tdo_oe_n, q_oe_n, q_func_oe;
    logic [BSR_LEN_DEFAULT-1:0] pins, preload;
    logic [Q_W_DEFAULT-1:0] q_func, q;
    logic [127:0] got, r, rq;
    logic [IR_W-1:0] cur;
    logic [31:0] seed = 32'h99d69e19;
    int n_mismatch = 0;
    int tests_run = 0;
    jbt_tap dut (
        .CLOCK_I(clk), .RST_I(rst), .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi), .TDO_O(tdo),
        .TDO_OE_N_O(tdo_oe_n), .PIN_STATE_I(pins), .Q_FUNC_I(q_func),
        .Q_FUNC_OE_I(q_func_oe), .Q_O(q), .Q_OE_N_O(q_oe_n)
    );
    jbt_jtag_ctl ctl (
        .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_n_i(tdo_oe_n)
    );
    always #5 clk = ~clk;
    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    always @(negedge clk) begin
        rq = {xs(), xs()};
        q_func <= rq[Q_W_DEFAULT-1:0];
        q_func_oe <= rq[40];
    end
    // ========
    // Comparison, verdict and scan helpers
    task chk(input logic [127:0] seen, input logic [127:0] want);
        tests_run++;
        if (seen !== want) begin
            n_mismatch++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, want);
        end
    endtask : chk
    task end_sim();
        if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim
    task ir_load(input logic [IR_W-1:0] code);
        ctl.scan(1'b1, IR_W, {125'h0, code}, got);
        chk(got[IR_W-1:0], IR_CAPTURE_VALUE);
        cur = code;
    endtask : ir_load
    task bsr_scan(input logic oe_bit);
        @(negedge clk);
        r = {xs(), xs(), xs(), xs()};
        pins = r[BSR_LEN_DEFAULT-1:0];
        r = {xs(), xs(), xs(), xs()};
        r[OE_CELL_DEFAULT] = oe_bit;
        ctl.scan(1'b0, BSR_LEN_DEFAULT, r, got);
        chk(got[BSR_LEN_DEFAULT-1:0], pins);
        preload = r[BSR_LEN_DEFAULT-1:0];
    endtask : bsr_scan
    task check_q();
        repeat (8) @(negedge clk);
        if (cur == INS_EXTEST) begin
            chk(q, preload[Q_W_DEFAULT-1:0]);
            chk(q_oe_n, !preload[OE_CELL_DEFAULT]);
        end else begin
            chk(q, q_func);
            chk(q_oe_n, cur == INS_SAMPLEZ ? 1'b1 : !q_func_oe);
        end
    endtask : check_q
    // ========
    // Main sequence
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        pins = '0;
        q_func = '0;
        q_func_oe = 1'b0;
        preload = '0;
        cur = INS_IDCODE;
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        chk(tdo_oe_n, 1'b1);
        ctl.tap_reset();
        ctl.scan(1'b0, ID_W, '0, got);
        chk(got[ID_W-1:0], ID_VALUE_DEFAULT);
        ir_load(INS_BYPASS);
        ctl.scan(1'b0, 8, 128'h5a, got);
        chk(got[7:0], {8'h5a << 1});
        check_q();
        ir_load(INS_SAMPLE);
        bsr_scan(1'b1);
        check_q();
        ir_load(INS_EXTEST);
        check_q();
        bsr_scan(1'b0);
        check_q();
        bsr_scan(1'b1);
        check_q();
        ctl.tap_reset();
        cur = INS_IDCODE;
        preload[OE_CELL_DEFAULT] = 1'b0;
        check_q();
        ctl.scan(1'b0, ID_W, '0, got);
        chk(got[ID_W-1:0], ID_VALUE_DEFAULT);
        ir_load(INS_EXTEST);
        check_q();
        ir_load(INS_SAMPLEZ);
        bsr_scan(1'b1);
        check_q();
        rst = 1'b1;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        ctl.tap_reset();
        cur = INS_IDCODE;
        preload = '0;
        ir_load(INS_EXTEST);
        check_q();
        end_sim();
    end
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end
endmodule : tb

bind jbt_tap jbt_tap_chk #(.BSR_LEN(BSR_LEN), .Q_W(Q_W), .ID_VALUE(ID_VALUE)) u_chk (
    .CLOCK_I(CLOCK_I), .RST_I(RST_I), .TCK_I(TCK_I), .TMS_I(TMS_I), .TDI_I(TDI_I),
    .TDO_O(TDO_O), .TDO_OE_N_O(TDO_OE_N_O), .PIN_STATE_I(PIN_STATE_I),
    .Q_FUNC_I(Q_FUNC_I), .Q_FUNC_OE_I(Q_FUNC_OE_I), .Q_O(Q_O), .Q_OE_N_O(Q_OE_N_O)
);

// File: verilog/jbt_scan_chain.sv
// One capture and shift scan register of the test port.
// Assumes capture and shift are never asserted together.
`timescale 1ns/100ps
module jbt_scan_chain #(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VALUE = '0
) (
    // Test clock and reset
    input wire logic tck_i,
    input wire logic rst_i,
    // Control
    input wire logic capture_i,
    input wire logic shift_i,
    input wire logic [W-1:0] capture_value_i,
    // Serial path
    input wire logic tdi_i,
    output logic [W-1:0] value_o,
    output logic serial_o
);
    logic [W-1:0] chain_reg;
    logic [W-1:0] chain_next;
    logic [W:0] shifted;

    always_comb begin
        shifted = {tdi_i, chain_reg};
        chain_next = chain_reg;
        if (capture_i) begin
            chain_next = capture_value_i;
        end else if (shift_i) begin
            chain_next = shifted[W:1];
        end
    end

    always_ff @(posedge tck_i or posedge rst_i) begin
        if (rst_i) begin
            chain_reg <= RESET_VALUE;
        end else begin
            chain_reg <= chain_next;
        end
    end

    assign value_o = chain_reg;
    assign serial_o = chain_reg[0];
endmodule : jbt_scan_chain

// File: verilog/jbt_sync.sv
// Two-flop synchroniser for level signals.
// Assumes inputs hold each level for several destination clock cycles.
`timescale 1ns/100ps
module jbt_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] stage1_reg;
    logic [W-1:0] stage2_reg;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= d_i;
            stage2_reg <= stage1_reg;
        end
    end

    assign q_o = stage2_reg;
endmodule : jbt_sync

// File: verilog/jbt_tap.sv
// Boundary scan test access port with its read-data output control.
// Assumes the test clock may stop between scans and is far slower than the
// core clock; pad pull-ups on mode select and serial input sit outside.
`timescale 1ns/100ps
module jbt_tap
    import jbt_pkg::*;
#(
    parameter int BSR_LEN = BSR_LEN_DEFAULT,
    parameter int OE_CELL = OE_CELL_DEFAULT,
    parameter int Q_W = Q_W_DEFAULT,
    parameter int Q_BASE = Q_BASE_DEFAULT,
    parameter logic [ID_W-1:0] ID_VALUE = ID_VALUE_DEFAULT
) (
    // Core clock and power-up reset
    input wire logic CLOCK_I,
    input wire logic RST_I,
    // Test port
    input wire logic TCK_I,
    input wire logic TMS_I,
    input wire logic TDI_I,
    output logic TDO_O,
    output logic TDO_OE_N_O,
    // Pin ring seen by the boundary cells
    input wire logic [BSR_LEN-1:0] PIN_STATE_I,
    // Functional read data from the memory core
    input wire logic [Q_W-1:0] Q_FUNC_I,
    input wire logic Q_FUNC_OE_I,
    // Read data pins
    output logic [Q_W-1:0] Q_O,
    output logic Q_OE_N_O
);

    // ==========================================================
    // Controller state machine
    jbt_state_type state_reg;
    jbt_state_type state_next;

    // Mode select is only ever sampled here, on the rising test clock
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_RESET: state_next = TMS_I ? ST_RESET : ST_IDLE;
            ST_IDLE: state_next = TMS_I ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: state_next = TMS_I ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_next = TMS_I ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: state_next = TMS_I ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: state_next = TMS_I ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: state_next = TMS_I ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: state_next = TMS_I ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: state_next = TMS_I ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: state_next = TMS_I ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: state_next = TMS_I ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: state_next = TMS_I ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: state_next = TMS_I ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: state_next = TMS_I ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: state_next = TMS_I ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: state_next = TMS_I ? ST_SEL_DR : ST_IDLE;
        endcase
    end

    // Sampled on the rising test clock
    always_ff @(posedge TCK_I or posedge RST_I) begin
        if (RST_I) begin
            state_reg <= ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // Instruction register
    logic [IR_W-1:0] ir_shift_reg;
    logic [IR_W-1:0] ir_shift_next;
    logic [IR_W-1:0] ir_reg;
    logic [IR_W-1:0] ir_next;

    always_comb begin
        ir_shift_next = ir_shift_reg;
        ir_next = ir_reg;
        unique case (state_reg)
            ST_RESET: begin
                ir_next = IR_RESET_VALUE;
            end
            ST_CAP_IR: begin
                ir_shift_next = IR_CAPTURE_VALUE;
            end
            ST_SHIFT_IR: begin
                ir_shift_next = {TDI_I, ir_shift_reg[IR_W-1:1]};
            end
            ST_UPD_IR: begin
                ir_next = ir_shift_reg;
            end
            default: begin
                ir_next = ir_reg;
            end
        endcase
    end

    always_ff @(posedge TCK_I or posedge RST_I) begin
        if (RST_I) begin
            ir_shift_reg <= IR_CAPTURE_VALUE;
            ir_reg <= IR_RESET_VALUE;
        end else begin
            ir_shift_reg <= ir_shift_next;
            ir_reg <= ir_next;
        end
    end

    // ==========================================================
    // Data register selection
    jbt_dr_sel_type dr_sel;
    logic in_cap_dr;
    logic in_shift_dr;
    logic bypass_serial;
    logic id_serial;
    logic bsr_serial;
    logic [BSR_LEN-1:0] bsr_value;
    logic [BSR_LEN-1:0] pin_sampled;

    // Reserved codes fall back to bypass so the path stays one bit long
    assign dr_sel = dr_select(ir_reg);
    assign in_cap_dr = (state_reg == ST_CAP_DR);
    assign in_shift_dr = (state_reg == ST_SHIFT_DR);

    jbt_scan_chain #(
        .W(1),
        .RESET_VALUE(BYPASS_CAPTURE_VALUE)
    ) u_bypass (
        .tck_i(TCK_I),
        .rst_i(RST_I),
        .capture_i(in_cap_dr && dr_sel == SEL_BYPASS),
        .shift_i(in_shift_dr && dr_sel == SEL_BYPASS),
        .capture_value_i(BYPASS_CAPTURE_VALUE),
        .tdi_i(TDI_I),
        .value_o(),
        .serial_o(bypass_serial)
    );

    jbt_scan_chain #(
        .W(ID_W),
        .RESET_VALUE(ID_VALUE)
    ) u_ident (
        .tck_i(TCK_I),
        .rst_i(RST_I),
        .capture_i(in_cap_dr && dr_sel == SEL_ID),
        .shift_i(in_shift_dr && dr_sel == SEL_ID),
        .capture_value_i(ID_VALUE),
        .tdi_i(TDI_I),
        .value_o(),
        .serial_o(id_serial)
    );

    // Pins change on the core clock; capture takes them as sampled two test clock rises before
    // the rise that ends Capture-DR, so the tester keeps them still from then on
    jbt_sync #(
        .W(BSR_LEN)
    ) u_pin_sync (
        .clk_i(TCK_I),
        .rst_i(RST_I),
        .d_i(PIN_STATE_I),
        .q_o(pin_sampled)
    );

    jbt_scan_chain #(
        .W(BSR_LEN),
        .RESET_VALUE('0)
    ) u_boundary (
        .tck_i(TCK_I),
        .rst_i(RST_I),
        .capture_i(in_cap_dr && dr_sel == SEL_BSR),
        .shift_i(in_shift_dr && dr_sel == SEL_BSR),
        .capture_value_i(pin_sampled),
        .tdi_i(TDI_I),
        .value_o(bsr_value),
        .serial_o(bsr_serial)
    );

    // ==========================================================
    // Latched parallel stage of the boundary cells
    logic [BSR_LEN-1:0] preload_reg;
    logic [BSR_LEN-1:0] preload_next;
    logic update_toggle_reg;
    logic update_toggle_next;

    always_comb begin
        preload_next = preload_reg;
        update_toggle_next = update_toggle_reg;
        if (state_reg == ST_RESET) begin
            preload_next[OE_CELL] = OE_CELL_RESET_VALUE;
            // The core keeps its own copy of the enable cell, so announce the clear
            if (preload_reg[OE_CELL] != OE_CELL_RESET_VALUE) begin
                update_toggle_next = ~update_toggle_reg;
            end
        end else if (state_reg == ST_UPD_DR && dr_sel == SEL_BSR) begin
            preload_next = bsr_value;
            update_toggle_next = ~update_toggle_reg;
        end
    end

    always_ff @(posedge TCK_I or posedge RST_I) begin
        if (RST_I) begin
            preload_reg <= '0;
            update_toggle_reg <= 1'h0;
        end else begin
            preload_reg <= preload_next;
            update_toggle_reg <= update_toggle_next;
        end
    end

    // ==========================================================
    // Serial output on the falling test clock
    logic tdo_reg;
    logic tdo_next;
    logic tdo_oe_n_reg;
    logic tdo_oe_n_next;

    always_comb begin
        tdo_next = tdo_reg;
        tdo_oe_n_next = 1'h1;
        if (state_reg == ST_SHIFT_IR) begin
            tdo_next = ir_shift_reg[0];
            tdo_oe_n_next = 1'h0;
        end else if (in_shift_dr) begin
            tdo_oe_n_next = 1'h0;
            unique case (dr_sel)
                SEL_ID: tdo_next = id_serial;
                SEL_BSR: tdo_next = bsr_serial;
                default: tdo_next = bypass_serial;
            endcase
        end
    end

    always_ff @(negedge TCK_I or posedge RST_I) begin
        if (RST_I) begin
            tdo_reg <= 1'h0;
            tdo_oe_n_reg <= 1'h1;
        end else begin
            tdo_reg <= tdo_next;
            tdo_oe_n_reg <= tdo_oe_n_next;
        end
    end

    assign TDO_O = tdo_reg;
    assign TDO_OE_N_O = tdo_oe_n_reg;

    // ==========================================================
    // Crossing into the core clock domain
    jbt_mode_type mode_tck;
    jbt_mode_type mode_core;
    logic toggle_core;

    // Modes follow the current instruction, so they change only at Update-IR and Test-Logic-Reset
    assign mode_tck.extest = (ir_reg == INS_EXTEST);
    assign mode_tck.float_q = (ir_reg == INS_SAMPLEZ);

    jbt_sync #(
        .W(SYNC_W)
    ) u_mode_sync (
        .clk_i(CLOCK_I),
        .rst_i(RST_I),
        .d_i({mode_tck, update_toggle_reg}),
        .q_o({mode_core, toggle_core})
    );

    // ==========================================================
    // Read data output control
    logic toggle_seen_reg;
    logic toggle_seen_next;
    logic [Q_W-1:0] q_pre_reg;
    logic [Q_W-1:0] q_pre_next;
    logic oe_pre_reg;
    logic oe_pre_next;
    logic [Q_W-1:0] q_reg;
    logic [Q_W-1:0] q_next;
    logic q_oe_n_reg;
    logic q_oe_n_next;

    // The latched stage holds still until the next Update-DR or Test-Logic-Reset, long after the
    // toggle has been seen here, so it is copied as a whole word
    always_comb begin
        toggle_seen_next = toggle_core;
        q_pre_next = q_pre_reg;
        oe_pre_next = oe_pre_reg;
        if (toggle_core != toggle_seen_reg) begin
            q_pre_next = preload_reg[Q_BASE +: Q_W];
            oe_pre_next = preload_reg[OE_CELL];
        end
        q_next = Q_FUNC_I;
        q_oe_n_next = ~Q_FUNC_OE_I;
        if (mode_core.float_q) begin
            q_oe_n_next = 1'h1;
        end else if (mode_core.extest) begin
            q_next = q_pre_reg;
            q_oe_n_next = ~oe_pre_reg;
        end
    end

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            toggle_seen_reg <= 1'h0;
            q_pre_reg <= '0;
            oe_pre_reg <= OE_CELL_RESET_VALUE;
            q_reg <= '0;
            q_oe_n_reg <= 1'h1;
        end else begin
            toggle_seen_reg <= toggle_seen_next;
            q_pre_reg <= q_pre_next;
            oe_pre_reg <= oe_pre_next;
            q_reg <= q_next;
            q_oe_n_reg <= q_oe_n_next;
        end
    end

    assign Q_O = q_reg;
    assign Q_OE_N_O = q_oe_n_reg;

endmodule : jbt_tap
